// >>> rtl/mso_status.sv
// motion status outputs: positioning done, speed reached, speed match, zero speed
`timescale 1ns/100ps
// Overview of operation
// - position window 0..10000 units, default 20
// - modes 0..2: window, no command, zero speed
// - mode 3: no command, window, settle timing
// - mode 4: wait delay after command ends
// - delay zero holds flag until next command
// - delay 1..15000 ms: off, then on
// - speed reached above threshold, default 1000
// - speed reached uses 10 rpm hysteresis
// - speed match when command-speed difference in window
module mso_status
  import mso_pkg::*;
#(
  parameter int TICK_CYCLES = MSO_TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register access
  input wire mso_reg_req_t reg_req_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // control loop samples, same clock
  input wire mso_loop_t loop_i,
  // status outputs
  output logic position_done_output_o,
  output logic speed_reached_flag_o,
  output logic speed_match_flag_o,
  output logic zero_speed_flag_o
);

  function automatic logic [16:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
  endfunction

  function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] lo,
                                       input logic [15:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] position_window_param_q;
  logic [15:0] position_condition_param_q;
  logic [15:0] settle_delay_param_q;
  logic [15:0] zero_speed_threshold_param_q;
  logic [15:0] speed_match_window_param_q;
  logic [15:0] speed_reached_threshold_param_q;
  logic position_done_flag_q, speed_reached_flag_q, speed_match_flag_q, zero_speed_flag_q;

  wire wr_pw = reg_req_i.wr && (reg_req_i.addr == MSO_OFS_POS_WINDOW);
  wire wr_pc = reg_req_i.wr && (reg_req_i.addr == MSO_OFS_POS_COND);
  wire wr_sd = reg_req_i.wr && (reg_req_i.addr == MSO_OFS_SETTLE_DELAY);
  wire wr_zs = reg_req_i.wr && (reg_req_i.addr == MSO_OFS_ZERO_SPEED);
  wire wr_sm = reg_req_i.wr && (reg_req_i.addr == MSO_OFS_SPEED_MATCH);
  wire wr_sr = reg_req_i.wr && (reg_req_i.addr == MSO_OFS_SPEED_REACHED);

  // writes other than the speed match window are clamped to the legal range so the comparators never see junk
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      position_window_param_q <= MSO_RST_POS_WINDOW;
      position_condition_param_q <= MSO_RST_POS_COND;
      settle_delay_param_q <= MSO_RST_SETTLE_DELAY;
      zero_speed_threshold_param_q <= MSO_RST_ZERO_SPEED;
      speed_match_window_param_q <= MSO_RST_SPEED_MATCH;
      speed_reached_threshold_param_q <= MSO_RST_SPEED_REACHED;
    end else begin
      if (wr_pw) position_window_param_q <= clip(reg_req_i.wdata, '0, MSO_MAX_POS_WINDOW);
      if (wr_pc) position_condition_param_q <= clip(reg_req_i.wdata, '0, MSO_MAX_POS_COND);
      if (wr_sd) settle_delay_param_q <= clip(reg_req_i.wdata, '0, MSO_MAX_SETTLE_DELAY);
      if (wr_zs) zero_speed_threshold_param_q <=
          clip(reg_req_i.wdata, MSO_MIN_ZERO_SPEED, MSO_MAX_ZERO_SPEED);
      if (wr_sm) speed_match_window_param_q <= reg_req_i.wdata;
      if (wr_sr) speed_reached_threshold_param_q <=
          clip(reg_req_i.wdata, MSO_MIN_SPEED_REACHED, MSO_MAX_SPEED_REACHED);
    end
  end

  // read mux; unmapped offsets read zero
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_req_i.addr)
      MSO_OFS_POS_WINDOW: rd_mux = position_window_param_q;
      MSO_OFS_POS_COND: rd_mux = position_condition_param_q;
      MSO_OFS_SETTLE_DELAY: rd_mux = settle_delay_param_q;
      MSO_OFS_ZERO_SPEED: rd_mux = zero_speed_threshold_param_q;
      MSO_OFS_SPEED_MATCH: rd_mux = speed_match_window_param_q;
      MSO_OFS_SPEED_REACHED: rd_mux = speed_reached_threshold_param_q;
      MSO_OFS_STATUS: begin
        rd_mux = '0;
        rd_mux[MSO_ST_POS_DONE] = position_done_flag_q;
        rd_mux[MSO_ST_SPEED_REACHED] = speed_reached_flag_q;
        rd_mux[MSO_ST_SPEED_MATCH] = speed_match_flag_q;
        rd_mux[MSO_ST_ZERO_SPEED] = zero_speed_flag_q;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_req_i.rd ? rd_mux : reg_rdata_o;
      reg_rvalid_o <= reg_req_i.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed comparators; thresholds read live so writes act next cycle
  wire [16:0] spd_abs = abs16(loop_i.motor_speed);
  wire [16:0] zs_thr = {1'b0, zero_speed_threshold_param_q};
  wire [16:0] sr_thr = {1'b0, speed_reached_threshold_param_q};
  wire zs_on = spd_abs < zs_thr;
  wire zs_off = spd_abs > 17'(zs_thr + MSO_HYST_RPM);
  // band of +/-10 rpm around the threshold keeps the flag quiet
  wire sr_on = spd_abs > 17'(sr_thr + MSO_HYST_RPM);
  wire sr_off = spd_abs < 17'(sr_thr - MSO_HYST_RPM);
  // velocity command is taken before acceleration shaping by the loop
  wire signed [16:0] vel_diff = 17'(loop_i.vel_cmd - loop_i.motor_speed);
  wire [16:0] vel_diff_abs = vel_diff[16] ? 17'(-vel_diff) : vel_diff;
  wire sm_in = vel_diff_abs <= {1'b0, speed_match_window_param_q};

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      zero_speed_flag_q <= 1'b0;
      speed_reached_flag_q <= 1'b0;
      speed_match_flag_q <= 1'b0;
    end else begin
      zero_speed_flag_q <= zs_on ? 1'b1 : (zs_off ? 1'b0 : zero_speed_flag_q);
      speed_reached_flag_q <= sr_on ? 1'b1 : (sr_off ? 1'b0 : speed_reached_flag_q);
      speed_match_flag_q <= sm_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // positioning complete
  wire [31:0] dev_abs = loop_i.pos_dev[31] ? 32'(-loop_i.pos_dev) : loop_i.pos_dev;
  wire in_win = dev_abs < {16'h0000, position_window_param_q};
  wire no_cmd = !loop_i.pos_cmd_active;
  mso_cond_t cond;
  assign cond = mso_cond_t'(position_condition_param_q[2:0]);

  // millisecond tick and settle timer
  localparam int TW = $clog2(TICK_CYCLES + 1);
  logic [TW-1:0] tick_cnt_q;
  logic [15:0] ms_cnt_q;
  logic cmd_seen_q;
  wire tick = tick_cnt_q == TW'(TICK_CYCLES - 1);
  wire timed = (cond == MSO_COND_SETTLE) || (cond == MSO_COND_DELAYED);
  wire delay_done = (settle_delay_param_q == '0) || (ms_cnt_q >= settle_delay_param_q);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || loop_i.pos_cmd_active) tick_cnt_q <= '0;
    else tick_cnt_q <= tick ? '0 : TW'(tick_cnt_q + 1'b1);
  end

  // timer restarts on each command and counts while the command is absent, stopping once it reaches the settle delay
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || loop_i.pos_cmd_active) ms_cnt_q <= '0;
    else if (tick && !delay_done) ms_cnt_q <= ms_cnt_q + 16'h0001;
  end

  logic pd_d;
  always_comb begin
    case (cond)
      MSO_COND_WINDOW: pd_d = in_win;
      MSO_COND_NO_CMD: pd_d = in_win && no_cmd;
      MSO_COND_ZERO_SPD: pd_d = in_win && no_cmd && zero_speed_flag_q;
      MSO_COND_SETTLE, MSO_COND_DELAYED: begin
        // after the delay: hold until the next command
        if (!no_cmd) pd_d = 1'b0;
        else if (!delay_done) pd_d = 1'b0;
        else if (position_done_flag_q && cmd_seen_q) pd_d = 1'b1;
        else pd_d = in_win;
      end
      default: pd_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      position_done_flag_q <= 1'b0;
      cmd_seen_q <= 1'b0;
    end else begin
      position_done_flag_q <= pd_d;
      cmd_seen_q <= timed && pd_d;
    end
  end

  assign position_done_output_o = position_done_flag_q;
  assign speed_reached_flag_o = speed_reached_flag_q;
  assign speed_match_flag_o = speed_match_flag_q;
  assign zero_speed_flag_o = zero_speed_flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_cmd_present;
    loop_i.pos_cmd_active;
  endsequence

  a_pd_cmd_clears: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (s_cmd_present ##0 (cond != MSO_COND_WINDOW)) |=> !position_done_output_o)
    else $error("position done set while command present");
  a_pd_mode0_win: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (cond == MSO_COND_WINDOW) |=> (position_done_output_o == $past(in_win)))
    else $error("mode 0 flag does not follow window");
  a_pd_mode2_zsp: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (cond == MSO_COND_ZERO_SPD && !zero_speed_flag_o) |=> !position_done_output_o)
    else $error("mode 2 flag set without zero speed");
  a_pd_delay_off: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (timed && !delay_done) |=> !position_done_output_o)
    else $error("flag on during settle delay");
  a_sr_hyst_on: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    sr_on |=> speed_reached_flag_o)
    else $error("speed reached missed");
  a_sr_hyst_off: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    sr_off |=> !speed_reached_flag_o)
    else $error("speed reached not released");
  a_zs_detect: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    zs_on |=> zero_speed_flag_o)
    else $error("zero speed missed");
  a_zs_release: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (zero_speed_flag_o && !zs_off && !zs_on) |=> zero_speed_flag_o)
    else $error("zero speed dropped inside band");
  a_sm_window: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    sm_in |=> speed_match_flag_o)
    else $error("speed match missed");
  // a flag stuck high would pass the check above, so guard the other side too
  a_sm_outside: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !sm_in |=> !speed_match_flag_o)
    else $error("speed match set outside window");
  a_cfg_next: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr_sr |=> (speed_reached_threshold_param_q ==
               clip($past(reg_req_i.wdata), MSO_MIN_SPEED_REACHED, MSO_MAX_SPEED_REACHED)))
    else $error("threshold write not taken");

endmodule // mso_status

// >>> rtl/mso_pkg.sv
// package for the motion status output block: register map, resets, timing, carriers
package mso_pkg;

  // register offsets (object index); two of them have no printed index
  localparam logic [15:0] MSO_OFS_POS_WINDOW = 16'h2431;
  localparam logic [15:0] MSO_OFS_POS_COND = 16'h2432;
  localparam logic [15:0] MSO_OFS_SETTLE_DELAY = 16'h2433;
  localparam logic [15:0] MSO_OFS_ZERO_SPEED = 16'h2434;
  localparam logic [15:0] MSO_OFS_SPEED_MATCH = 16'h2435;
  localparam logic [15:0] MSO_OFS_SPEED_REACHED = 16'h2436;
  localparam logic [15:0] MSO_OFS_STATUS = 16'h2437;

  // reset values
  localparam logic [15:0] MSO_RST_POS_WINDOW = 16'h0014;
  localparam logic [15:0] MSO_RST_POS_COND = 16'h0001;
  localparam logic [15:0] MSO_RST_SETTLE_DELAY = 16'h0000;
  localparam logic [15:0] MSO_RST_ZERO_SPEED = 16'h0032;
  localparam logic [15:0] MSO_RST_SPEED_MATCH = 16'h000A;
  localparam logic [15:0] MSO_RST_SPEED_REACHED = 16'h03E8;

  // legal ranges of the settings
  localparam logic [15:0] MSO_MAX_POS_WINDOW = 16'h2710;
  localparam logic [15:0] MSO_MAX_POS_COND = 16'h0004;
  localparam logic [15:0] MSO_MAX_SETTLE_DELAY = 16'h3A98;
  localparam logic [15:0] MSO_MIN_ZERO_SPEED = 16'h0001;
  localparam logic [15:0] MSO_MAX_ZERO_SPEED = 16'h07D0;
  localparam logic [15:0] MSO_MIN_SPEED_REACHED = 16'h000A;
  localparam logic [15:0] MSO_MAX_SPEED_REACHED = 16'h07D0;

  // hysteresis band in rpm
  localparam logic [16:0] MSO_HYST_RPM = 17'h0000A;

  // time base: one millisecond at the 250 MHz clock
  localparam int MSO_CLK_MHZ = 250;
  localparam int MSO_TICK_US = 1000;
  localparam int MSO_TICK_CYCLES = MSO_CLK_MHZ * MSO_TICK_US;

  // status word bit positions
  localparam int MSO_ST_POS_DONE = 0;
  localparam int MSO_ST_SPEED_REACHED = 1;
  localparam int MSO_ST_SPEED_MATCH = 2;
  localparam int MSO_ST_ZERO_SPEED = 3;

  // positioning-complete condition codes
  typedef enum logic [2:0] {
    MSO_COND_WINDOW, MSO_COND_NO_CMD, MSO_COND_ZERO_SPD, MSO_COND_SETTLE, MSO_COND_DELAYED
  } mso_cond_t;

  // register write/read request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mso_reg_req_t;

  // control-loop sample
  typedef struct packed {
    logic signed [31:0] pos_dev;
    logic pos_cmd_active;
    logic signed [15:0] motor_speed;
    logic signed [15:0] vel_cmd;
  } mso_loop_t;

endpackage

// >>> sim/mso_ctrl_model.sv
// behavioural motion controller that feeds control-loop samples to the block
`timescale 1ns/100ps
module mso_ctrl_model
  import mso_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // sample requested by the bench
  input wire mso_loop_t set_i,
  // sample as the control loop presents it
  output mso_loop_t loop_o
);
  // one loop cycle of latency, like the servo loop pipeline it stands for
  always @(posedge sys_clk_i) begin
    loop_o <= set_i;
  end
endmodule // mso_ctrl_model

// >>> sim/test_motion_status_outputs.sv
// self-checking bench for the motion status outputs block
`timescale 1ns/100ps
module test_motion_status_outputs
  import mso_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  mso_reg_req_t req = '0;
  mso_loop_t set = '0;
  mso_loop_t loop;
  logic [15:0] rdata;
  logic rvalid, pd, sr, sm, zs;
  int err_total = 0;
  int n_checks = 0;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h00016053;
  //////////////////////////////////////////////////////////////////////////
  // clock, partner and device; short tick keeps the settle delay cheap
  initial forever #2 sys_clk_i = ~sys_clk_i;
  mso_ctrl_model i_ctrl (.sys_clk_i(sys_clk_i), .set_i(set), .loop_o(loop));
  mso_status #(.TICK_CYCLES(4)) i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .loop_i(loop),
    .position_done_output_o(pd), .speed_reached_flag_o(sr),
    .speed_match_flag_o(sm), .zero_speed_flag_o(zs));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t read data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t flag pins %b expected %b", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // strobes last exactly one rising edge, launched on the falling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk_i);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge sys_clk_i);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    exp_q.push_back(e);
    @(negedge sys_clk_i);
    req.rd = 1'b0;
  endtask
  task automatic st(input logic p, input logic s, input logic m, input logic z);
    rd(MSO_OFS_STATUS, {12'h000, z, m, s, p});
    // pins are levels; loop sample is unchanged since the read, so they still stand
    chk_flags({zs, sm, sr, pd}, {z, m, s, p});
  endtask
  // partner sample, then time for loop and flag registers to settle
  task automatic drive(input int d, input logic c, input int s, input int v);
    set = '{pos_dev: 32'(d), pos_cmd_active: c, motor_speed: 16'(s), vel_cmd: 16'(v)};
    repeat (3) @(negedge sys_clk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // answers are matched against the oldest pending note
  always @(negedge sys_clk_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("FAIL %0t read answer with no request", $time);
      end else begin
        chk16(rdata, exp_q.pop_front());
      end
    end
  end
  // hang guard
  initial begin
    #100000;
    err_total++;
    $display("FAIL %0t run timed out", $time);
    final_report();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    int s, v, d, a;
    logic [31:0] r;
    logic p_zs, p_sr;
    repeat (10) @(negedge sys_clk_i);
    srst_i = 1'b0;
    // reset values, unmapped place, clamping
    rd(MSO_OFS_POS_WINDOW, MSO_RST_POS_WINDOW);
    rd(MSO_OFS_POS_COND, MSO_RST_POS_COND);
    rd(MSO_OFS_SETTLE_DELAY, MSO_RST_SETTLE_DELAY);
    rd(MSO_OFS_ZERO_SPEED, MSO_RST_ZERO_SPEED);
    rd(MSO_OFS_SPEED_MATCH, MSO_RST_SPEED_MATCH);
    rd(MSO_OFS_SPEED_REACHED, MSO_RST_SPEED_REACHED);
    rd(16'h2438, 16'h0000);
    st(1'b1, 1'b0, 1'b1, 1'b1);
    wr(MSO_OFS_POS_WINDOW, 16'hFFFF);
    rd(MSO_OFS_POS_WINDOW, MSO_MAX_POS_WINDOW);
    wr(MSO_OFS_POS_WINDOW, 16'h0014);
    wr(MSO_OFS_SPEED_REACHED, 16'h0064);
    wr(MSO_OFS_POS_COND, 16'h0000);
    // random speeds in both directions; bench tracks both hysteresis states
    p_zs = 1'b1;
    p_sr = 1'b0;
    for (int i = 0; i < 200; i++) begin
      r = xs();
      s = int'(xs() % 32'd401) - 200;
      v = s + int'(xs() % 32'd31) - 15;
      d = int'(xs() % 32'd81) - 40;
      a = (s < 0) ? -s : s;
      if (a < 50) p_zs = 1'b1;
      else if (a > 60) p_zs = 1'b0;
      if (a > 110) p_sr = 1'b1;
      else if (a < 90) p_sr = 1'b0;
      drive(d, r[7], s, v);
      st(d < 20 && d > -20, p_sr, v - s <= 10 && s - v <= 10, p_zs);
    end
    // condition modes 1 and 2, new setting acts at once
    wr(MSO_OFS_POS_COND, 16'h0001);
    drive(0, 1'b1, 0, 0);
    st(1'b0, 1'b0, 1'b1, 1'b1);
    drive(0, 1'b0, 0, 0);
    st(1'b1, 1'b0, 1'b1, 1'b1);
    wr(MSO_OFS_POS_COND, 16'h0002);
    drive(5, 1'b0, 70, 70);
    st(1'b0, 1'b0, 1'b1, 1'b0);
    drive(5, 1'b0, 0, 0);
    st(1'b1, 1'b0, 1'b1, 1'b1);
    // mode 4 with a 3 ms settle delay, then latched until next command
    wr(MSO_OFS_POS_COND, 16'h0004);
    wr(MSO_OFS_SETTLE_DELAY, 16'h0003);
    drive(0, 1'b1, 0, 0);
    drive(0, 1'b0, 0, 0);
    st(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (20) @(negedge sys_clk_i);
    st(1'b1, 1'b0, 1'b1, 1'b1);
    drive(500, 1'b0, 0, 0);
    st(1'b1, 1'b0, 1'b1, 1'b1);
    drive(0, 1'b1, 0, 0);
    st(1'b0, 1'b0, 1'b1, 1'b1);
    // mode 3 with unlimited hold
    wr(MSO_OFS_POS_COND, 16'h0003);
    wr(MSO_OFS_SETTLE_DELAY, 16'h0000);
    drive(0, 1'b0, 0, 0);
    st(1'b1, 1'b0, 1'b1, 1'b1);
    drive(500, 1'b0, 0, 0);
    st(1'b1, 1'b0, 1'b1, 1'b1);
    drive(500, 1'b1, 0, 0);
    drive(500, 1'b0, 0, 0);
    st(1'b0, 1'b0, 1'b1, 1'b1);
    // low limits clamp, wider match window, all act on the next sample
    wr(MSO_OFS_ZERO_SPEED, 16'h0000);
    rd(MSO_OFS_ZERO_SPEED, MSO_MIN_ZERO_SPEED);
    wr(MSO_OFS_SPEED_REACHED, 16'h0000);
    rd(MSO_OFS_SPEED_REACHED, MSO_MIN_SPEED_REACHED);
    wr(MSO_OFS_SPEED_MATCH, 16'h0014);
    rd(MSO_OFS_SPEED_MATCH, 16'h0014);
    drive(0, 1'b0, 30, 50);
    st(1'b1, 1'b1, 1'b1, 1'b0);
    wr(MSO_OFS_SETTLE_DELAY, 16'hFFFF);
    rd(MSO_OFS_SETTLE_DELAY, MSO_MAX_SETTLE_DELAY);
    // drain outstanding answers under a bound
    for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(negedge sys_clk_i);
    if (exp_q.size() > 0) begin
      err_total++;
      $display("FAIL %0t read answers missing", $time);
    end
    final_report();
  end
endmodule // test_motion_status_outputs
